// *** rtl/srbg_pkg.sv ***
// Package with register map, field positions, reset values and scale constants for the rate generator
package srbg_pkg;
    // Register byte offsets, one aligned word each
    localparam logic [4:0] OFS_RATE_CONTROL = 5'h00;
    localparam logic [4:0] OFS_DIVISOR_LOW  = 5'h04;
    localparam logic [4:0] OFS_DIVISOR_HIGH = 5'h08;
    localparam logic [4:0] OFS_MODE_CONTROL = 5'h0c;
    localparam logic [4:0] OFS_IRQ_STATUS   = 5'h10;
    localparam logic [4:0] OFS_IRQ_CLEAR    = 5'h14;
    localparam logic [4:0] OFS_IRQ_ENABLE   = 5'h18;
    // rate_control field positions
    localparam int BIT_AUTO_OVERFLOW  = 7;
    localparam int BIT_RX_IDLE        = 6;
    localparam int BIT_CLOCK_POLARITY = 4;
    localparam int BIT_DIVIDER_WIDTH  = 3;
    localparam int BIT_WAKE_ENABLE    = 1;
    localparam int BIT_AUTO_ENABLE    = 0;
    // mode_control field positions
    localparam int BIT_SYNC_MODE      = 0;
    localparam int BIT_HIGH_RATE      = 1;
    // Interrupt event positions
    localparam int IRQ_RECEIVE_FLAG   = 0;
    localparam int IRQ_AUTO_DONE      = 1;
    localparam int IRQ_AUTO_OVERFLOW  = 2;
    localparam int IRQ_COUNT          = 3;
    // Reset values
    localparam logic [15:0] DIVISOR_RESET = 16'h0000;
    localparam logic [7:0]  CTRL_RESET    = 8'h00;
    // Prescale terminal counts (multiplier minus one)
    localparam logic [5:0] SCALE_64_M1 = 6'h3f;
    localparam logic [5:0] SCALE_16_M1 = 6'h0f;
    localparam logic [5:0] SCALE_4_M1  = 6'h03;
    // Auto-rate measures this many further falling edges after the first
    localparam logic [2:0] AUTO_EDGES  = 3'h4;
    // Auto-rate measurement states, Gray along the path
    typedef enum logic [1:0] {
        ABD_IDLE = 2'b00,
        ABD_WAIT = 2'b01,
        ABD_MEAS = 2'b11
    } srbg_abd_t;
endpackage

// *** rtl/srbg_rate_if.sv ***
// Interface carrying rate timer setup and tick between the top and the timer
`timescale 1ns/1ps
`default_nettype none
interface srbg_rate_if;
    logic        restart;  // Clear the timer at once
    logic [15:0] divisor;  // Divisor value n
    logic        wide;     // 16-bit divider when high
    logic [5:0]  scale;    // Prescale terminal count
    logic        tick;     // One bit period elapsed

    modport ctrl  (output restart, output divisor, output wide, output scale, input tick);
    modport timer (input restart, input divisor, input wide, input scale, output tick);
endinterface
`default_nettype wire

// *** rtl/srbg_rate_timer.sv ***
// Free-running rate timer: prescaler followed by divisor counter
`timescale 1ns/1ps
`default_nettype none
module srbg_rate_timer
    import srbg_pkg::*;
(
    input wire logic         clock,
    input wire logic         reset_n,
    srbg_rate_if.timer       rif
);
    logic [5:0]  pre_q;    // Prescale count
    logic [15:0] cnt_q;    // Divisor count
    logic        tick_q;   // Registered tick
    logic [15:0] limit;    // Effective divisor
    logic        pre_end;  // Prescaler wrap

    // Narrow mode sees only the low byte
    assign limit   = rif.wide ? rif.divisor : {8'h00, rif.divisor[7:0]};
    assign pre_end = (pre_q == rif.scale);
    assign rif.tick = tick_q;

    // Prescaler supplies the multiplier of the period
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            pre_q <= 6'h00;
        else if (rif.restart)
            pre_q <= 6'h00;
        else if (pre_end)
            pre_q <= 6'h00;
        else
            pre_q <= pre_q + 6'h01;
    end

    // Divisor counter gives n+1 prescale periods
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            cnt_q <= 16'h0000;
        else if (rif.restart)
            cnt_q <= 16'h0000;
        else if (pre_end)
        begin
            if (cnt_q >= limit)
                cnt_q <= 16'h0000;
            else
                cnt_q <= cnt_q + 16'h0001;
        end
    end

    // Tick on the first clock after each bit period ends
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            tick_q <= 1'b0;
        else
            tick_q <= !rif.restart && pre_end && (cnt_q >= limit);
    end
endmodule // srbg_rate_timer
`default_nettype wire

// *** rtl/srbg_top.sv ***
// Serial port rate generator with rate control register, wake and auto-rate logic
//
// Function
// - Async: polarity bit inverts transmit pin data
// - Sync: polarity picks rising or falling edge
// - Width bit picks 16-bit or 8-bit divider
// - Wake: falling edge sets flag, clears enable
// - Reset gives 8-bit; one generator both modes
// - Divisor byte pair sets timer period
// - Async multiplier depends on high-rate, width
// - Sync mode ignores high-rate select
// - Divisor write clears rate timer immediately
// - Rates: 64(n+1), 16(n+1), 4(n+1)
// - Idle flag one when idle, else zero
`timescale 1ns/1ps
`default_nettype none
module srbg_top
    import srbg_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        reset_n,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        rx_pin,
    input  wire logic        link_clock,
    input  wire logic        tx_data,
    input  wire logic        rx_busy,
    output logic             transmit_clock_pin,
    output logic             rate_tick,
    output logic             data_strobe,
    output logic             receive_flag,
    output logic             irq
);
    import srbg_pkg::*;

    srbg_rate_if rif ();  // Link to the rate timer

    // Control state
    logic        pol_q; // clock_polarity_select
    logic        wide_q; // divider_width_select
    logic        wake_q; // wake_on_edge_enable
    logic        auto_q; // auto_rate_detect_enable
    logic        ovf_q; // Auto-rate overflow
    logic        sync_q; // Synchronous mode
    logic        high_q; // high_rate_select
    logic [15:0] div_q; // Divisor byte pair
    logic [IRQ_COUNT-1:0] ist_q; // Sticky events
    logic [IRQ_COUNT-1:0] ien_q; // Event enables
    // Bus slave state
    logic        wait_q; // waitrequest
    logic [31:0] rdata_q; // Read data
    // Output flops
    logic        pin_q; // Transmit pin
    logic        tick_q; // Rate tick copy
    logic        strobe_q; // Sync sample strobe
    logic        rflag_q; // Receive flag pulse
    logic        irq_q; // Interrupt level
    // Input synchronisers: index 0 receive pin, 1 link clock
    logic [2:0]  sync_s_q [2]; // Three-stage chains
    logic        lvl_q [2]; // Filtered levels, one process each
    logic [1:0]  chg; // Accepted change
    // Auto-rate measurement
    srbg_abd_t   abd_q; // Measurement state
    logic [8:0]  apre_q; // Eight-bit-time prescale
    logic [16:0] acnt_q; // Measured count
    logic [2:0]  aedge_q; // Falling edges seen
    // Decoded strobes
    logic        wr_acc; // Write taken this edge
    logic        rd_acc; // Read sampled this edge
    logic        rx_fall; // Receive pin fell
    logic        wake_hit; // Wake edge event
    logic        abd_done; // Measurement complete
    logic        abd_over; // Measurement overflow
    logic        div_wr; // Divisor write
    logic [IRQ_COUNT-1:0] ev; // Event pulses
    logic [IRQ_COUNT-1:0] clr; // Clear pulses
    logic [7:0]  wbyte; // Lane 0 write data

    // A write is taken one edge after waitrequest drops; a read is sampled at the edge where it drops
    assign wr_acc = avs_write && !wait_q && avs_byteenable[0];
    assign rd_acc = avs_read && wait_q;
    assign wbyte  = avs_writedata[7:0];
    assign div_wr = wr_acc && ((avs_address == OFS_DIVISOR_LOW) || (avs_address == OFS_DIVISOR_HIGH));

    // Synchronisers: a change counts once stages two and three agree
    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_sync
            always_ff @(posedge clock or negedge reset_n)
            begin
                if (!reset_n)
                begin
                    sync_s_q[g] <= (g == 0) ? 3'h7 : 3'h0; // Idle levels: no false edge
                    lvl_q[g]    <= (g == 0);
                end
                else
                begin
                    sync_s_q[g] <= {sync_s_q[g][1:0], (g == 0) ? rx_pin : link_clock};
                    if (chg[g])
                        lvl_q[g] <= sync_s_q[g][2];
                end
            end
            assign chg[g] = (sync_s_q[g][1] == sync_s_q[g][2]) && (sync_s_q[g][2] != lvl_q[g]);
        end
    endgenerate

    assign rx_fall  = chg[0] && !sync_s_q[0][2];
    assign wake_hit = !sync_q && wake_q && rx_fall;

    // Timer setup; sync mode drops high-rate from the choice
    always_comb
    begin
        rif.restart = div_wr || abd_done;
        rif.divisor = div_q;
        rif.wide    = wide_q;
        if (sync_q)
            rif.scale = SCALE_4_M1;
        else if (!wide_q && !high_q)
            rif.scale = SCALE_64_M1;
        else if (wide_q && high_q)
            rif.scale = SCALE_4_M1;
        else
            rif.scale = SCALE_16_M1;
    end

    srbg_rate_timer u_timer (
        .clock   (clock),
        .reset_n (reset_n),
        .rif     (rif)
    );

    // Auto-rate measurement control
    assign abd_over = (abd_q == ABD_MEAS) && acnt_q[16];
    assign abd_done = (abd_q == ABD_MEAS) && rx_fall && (aedge_q == AUTO_EDGES - 3'h1) && !acnt_q[16];

    // Measure eight bit times between first and fifth falling edge
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            abd_q <= ABD_IDLE;
        else
        begin
            case (abd_q)
                ABD_IDLE:
                    if (auto_q && !sync_q)
                        abd_q <= ABD_WAIT;
                ABD_WAIT:
                    if (!auto_q || sync_q)
                        abd_q <= ABD_IDLE;
                    else if (rx_fall)
                        abd_q <= ABD_MEAS;
                ABD_MEAS:
                    if (abd_done || abd_over || !auto_q)
                        abd_q <= ABD_IDLE;
                default:
                    abd_q <= ABD_IDLE;
            endcase
        end
    end

    // Count in units of eight times the multiplier
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            apre_q  <= 9'h000;
            acnt_q  <= 17'h00000;
            aedge_q <= 3'h0;
        end
        else if (abd_q != ABD_MEAS)
        begin
            apre_q  <= 9'h000;
            acnt_q  <= 17'h00000;
            aedge_q <= 3'h0;
        end
        else
        begin
            if (apre_q == {rif.scale, 3'h7})
            begin
                apre_q <= 9'h000;
                acnt_q <= acnt_q + 17'h00001;
            end
            else
                apre_q <= apre_q + 9'h001;
            if (rx_fall)
                aedge_q <= aedge_q + 3'h1;
        end
    end

    // Rate control bits; hardware clears win over the same-cycle write
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pol_q  <= CTRL_RESET[BIT_CLOCK_POLARITY];
            wide_q <= CTRL_RESET[BIT_DIVIDER_WIDTH];
            wake_q <= CTRL_RESET[BIT_WAKE_ENABLE];
            auto_q <= CTRL_RESET[BIT_AUTO_ENABLE];
            ovf_q  <= CTRL_RESET[BIT_AUTO_OVERFLOW];
        end
        else
        begin
            if (wr_acc && avs_address == OFS_RATE_CONTROL)
            begin
                pol_q  <= wbyte[BIT_CLOCK_POLARITY];
                wide_q <= wbyte[BIT_DIVIDER_WIDTH];
                wake_q <= wbyte[BIT_WAKE_ENABLE];
                auto_q <= wbyte[BIT_AUTO_ENABLE];
                ovf_q  <= wbyte[BIT_AUTO_OVERFLOW];
            end
            if (wake_hit)
                wake_q <= 1'b0;
            if (abd_done || abd_over)
                auto_q <= 1'b0;
            if (abd_over)
                ovf_q <= 1'b1;
        end
    end

    // Mode bits and divisor; auto-rate result loads n
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sync_q <= 1'b0;
            high_q <= 1'b0;
            div_q  <= DIVISOR_RESET;
        end
        else
        begin
            if (wr_acc && avs_address == OFS_MODE_CONTROL)
            begin
                sync_q <= wbyte[BIT_SYNC_MODE];
                high_q <= wbyte[BIT_HIGH_RATE];
            end
            if (abd_done)
                div_q <= acnt_q[15:0] - 16'h0001;
            else if (wr_acc && avs_address == OFS_DIVISOR_LOW)
                div_q[7:0] <= wbyte;
            else if (wr_acc && avs_address == OFS_DIVISOR_HIGH)
                div_q[15:8] <= wbyte;
        end
    end

    // Events and clears for the sticky status
    assign ev[IRQ_RECEIVE_FLAG]  = wake_hit;
    assign ev[IRQ_AUTO_DONE]     = abd_done;
    assign ev[IRQ_AUTO_OVERFLOW] = abd_over;
    assign clr = (wr_acc && avs_address == OFS_IRQ_CLEAR) ? wbyte[IRQ_COUNT-1:0] : '0;

    // Sticky status: a new event beats a same-cycle clear
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            ist_q <= '0;
        else
            ist_q <= (ist_q & ~clr) | ev;
    end

    // Interrupt enables
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            ien_q <= '0;
        else if (wr_acc && avs_address == OFS_IRQ_ENABLE)
            ien_q <= wbyte[IRQ_COUNT-1:0];
    end

    // Waitrequest drops for one cycle per request
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            wait_q <= 1'b1;
        else if (wait_q)
            wait_q <= !(avs_read || avs_write);
        else
            wait_q <= 1'b1;
    end

    // Read mux sampled as waitrequest falls; unmapped reads zero
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            rdata_q <= 32'h0000_0000;
        else if (rd_acc)
        begin
            rdata_q <= 32'h0000_0000;
            if (avs_address == OFS_RATE_CONTROL)
            begin
                rdata_q[BIT_AUTO_OVERFLOW]  <= ovf_q;
                rdata_q[BIT_RX_IDLE]        <= !rx_busy;
                rdata_q[BIT_CLOCK_POLARITY] <= pol_q;
                rdata_q[BIT_DIVIDER_WIDTH]  <= wide_q;
                rdata_q[BIT_WAKE_ENABLE]    <= wake_q;
                rdata_q[BIT_AUTO_ENABLE]    <= auto_q;
            end
            else if (avs_address == OFS_DIVISOR_LOW)
                rdata_q[7:0] <= div_q[7:0];
            else if (avs_address == OFS_DIVISOR_HIGH)
                rdata_q[7:0] <= div_q[15:8];
            else if (avs_address == OFS_MODE_CONTROL)
            begin
                rdata_q[BIT_SYNC_MODE] <= sync_q;
                rdata_q[BIT_HIGH_RATE] <= high_q;
            end
            else if (avs_address == OFS_IRQ_STATUS)
                rdata_q[IRQ_COUNT-1:0] <= ist_q;
            else if (avs_address == OFS_IRQ_ENABLE)
                rdata_q[IRQ_COUNT-1:0] <= ien_q;
        end
    end

    // Transmit pin: inverted data only in async mode
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            pin_q <= 1'b1;
        else if (!sync_q)
            pin_q <= tx_data ^ pol_q;
        else
            pin_q <= tx_data;
    end

    // Sync strobe on the link clock edge chosen by polarity
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            strobe_q <= 1'b0;
        else
            strobe_q <= sync_q && chg[1] && (sync_s_q[1][2] == pol_q);
    end

    // Registered pulses and interrupt level
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            tick_q  <= 1'b0;
            rflag_q <= 1'b0;
            irq_q   <= 1'b0;
        end
        else
        begin
            tick_q  <= rif.tick;
            rflag_q <= wake_hit;
            irq_q   <= |((((ist_q & ~clr) | ev)) & ien_q);
        end
    end

    assign avs_readdata = rdata_q;
    assign avs_waitrequest = wait_q;
    assign transmit_clock_pin = pin_q;
    assign rate_tick = tick_q;
    assign data_strobe = strobe_q;
    assign receive_flag = rflag_q;
    assign irq = irq_q;
endmodule // srbg_top
`default_nettype wire

// *** bench/srbg_checker.sv ***
// Port checker for the rate generator, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module srbg_checker
    import srbg_pkg::*;
(
    input wire logic        clock,
    input wire logic        reset_n,
    input wire logic [4:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        rx_pin,
    input wire logic        link_clock,
    input wire logic        tx_data,
    input wire logic        transmit_clock_pin,
    input wire logic        rate_tick,
    input wire logic        data_strobe,
    input wire logic        receive_flag
);
    logic        wr_ok; // Accepted write, lane 0 set
    logic        pol_q, wide_q, sync_q, high_q; // Shadow of mode bits
    logic        wake_q, free_q, chg_q; // Wake shadow, no auto load, settings moved
    logic [15:0] div_q; // Divisor shadow
    logic [23:0] cnt_q; // Clocks since the last tick
    logic [23:0] mul, per; // Multiplier and expected period
    assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
    assign mul   = sync_q ? 24'h4 : (wide_q ^ high_q) ? 24'h10 : wide_q ? 24'h4 : 24'h40;
    assign per   = mul * ({8'h0, wide_q ? div_q : {8'h0, div_q[7:0]}} + 24'h1);
    // Settings follow accepted writes
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            {pol_q, wide_q, sync_q, high_q, div_q} <= 20'h0;
        else if (wr_ok)
        begin
            case (avs_address)
                OFS_RATE_CONTROL: {pol_q, wide_q} <= avs_writedata[4:3];
                OFS_MODE_CONTROL: {high_q, sync_q} <= avs_writedata[1:0];
                OFS_DIVISOR_LOW:  div_q[7:0] <= avs_writedata[7:0];
                OFS_DIVISOR_HIGH: div_q[15:8] <= avs_writedata[7:0];
                default:          ;
            endcase
        end
    end
    // Bits the hardware clears itself; auto-rate loads an unseen divisor
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            {wake_q, free_q} <= 2'b01;
        else if (receive_flag)
            wake_q <= 1'b0;
        else if (wr_ok && avs_address == OFS_RATE_CONTROL)
            {wake_q, free_q} <= {avs_writedata[1], free_q & !avs_writedata[0]};
        else if (wr_ok && avs_address == OFS_DIVISOR_LOW)
            free_q <= 1'b1;
    end
    // Period count; a settings write voids the next gap
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            {cnt_q, chg_q} <= {24'h0, 1'b1};
        else
        begin
            cnt_q <= rate_tick ? 24'h1 : cnt_q + 24'h1;
            chg_q <= (wr_ok && avs_address <= OFS_MODE_CONTROL) || (chg_q && !rate_tick);
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    sequence s_link_edge;
        sync_q && (pol_q ? $rose(link_clock) : $fell(link_clock));
    endsequence
    sequence s_wake_edge;
        $fell(rx_pin) && wake_q && !sync_q;
    endsequence
    property p_wait_ans;
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    a_wait_ans: assert property (p_wait_ans) else $error("bus request not answered");
    property p_period;
        rate_tick && !chg_q && free_q |-> cnt_q == per;
    endproperty
    a_period: assert property (p_period) else $error("tick period wrong");
    property p_pin;
        $past(reset_n) |-> transmit_clock_pin == $past(tx_data ^ (pol_q & !sync_q));
    endproperty
    a_pin: assert property (p_pin) else $error("pin data polarity wrong");
    property p_strobe_lvl;
        data_strobe |-> sync_q && link_clock == pol_q;
    endproperty
    a_strobe_lvl: assert property (p_strobe_lvl) else $error("strobe on wrong edge");
    property p_strobe_edge;
        s_link_edge |-> ##[2:7] data_strobe;
    endproperty
    a_strobe_edge: assert property (p_strobe_edge) else $error("link edge not strobed");
    property p_wake_edge;
        s_wake_edge |-> ##[2:6] receive_flag;
    endproperty
    a_wake_edge: assert property (p_wake_edge) else $error("wake edge gave no flag");
    property p_flag_cause;
        receive_flag |-> wake_q ##1 !receive_flag;
    endproperty
    a_flag_cause: assert property (p_flag_cause) else $error("flag without wake");
    property p_read_zero;
        avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0
            && ((avs_address <= OFS_IRQ_ENABLE && avs_address[1:0] == 2'h0) || avs_readdata == 32'h0);
    endproperty
    a_read_zero: assert property (p_read_zero) else $error("unused read bits not zero");
endmodule // srbg_checker
bind srbg_top srbg_checker u_chk (.*);
`default_nettype wire

// *** bench/srbg_line_model.sv ***
// Line model: remote transmitter on the receive line and sync clock source
`timescale 1ns/1ps
`default_nettype none
module srbg_line_model
(
    input  wire logic clock,
    output var logic  rx_pin,
    output var logic  link_clock
);
    // Line idles high, link clock stands low outside bursts
    initial
    begin
        rx_pin     = 1'b1;
        link_clock = 1'b0;
    end
    // Start bit, eight data bits lsb first, stop bit
    task automatic send_char(input logic [7:0] ch, input int bit_clks);
        logic [9:0] frame;
        frame = {1'b1, ch, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            rx_pin <= frame[i];
            repeat (bit_clks) @(posedge clock);
        end
    endtask
    // Burst at 125 ns, phase unrelated to the system clock
    task automatic clock_burst(input int n);
        #3.3;
        repeat (n)
        begin
            link_clock = 1'b1;
            #62.5;
            link_clock = 1'b0;
            #62.5;
        end
    endtask
endmodule // srbg_line_model
`default_nettype wire

// *** bench/srbg_top_tb.sv ***
// Testbench: register tasks and rate, pin, strobe, wake and auto-rate tests
`timescale 1ns/1ps
`default_nettype none
module srbg_top_tb;
    import srbg_pkg::*;
    logic        clock, reset_n, avs_read, avs_write, tx_data, rx_busy; // Driven inputs
    logic [4:0]  avs_address; // Byte address
    logic [31:0] avs_writedata, avs_readdata; // Bus data
    logic [3:0]  avs_byteenable; // Lanes
    logic        avs_waitrequest, transmit_clock_pin, rate_tick; // Outputs
    logic        data_strobe, receive_flag, irq, rx_pin, link_clock; // Outputs, line
    int          n_mismatch, n_tests; // Tallies
    int          mul [7] = '{64, 16, 16, 4, 4, 4, 4}; // Period multipliers
    logic [7:0]  md  [7] = '{8'h0, 8'h0, 8'h2, 8'h2, 8'h1, 8'h3, 8'h3}; // Sync and high-rate
    logic [7:0]  ct  [7] = '{8'h0, 8'h8, 8'h0, 8'h8, 8'h0, 8'h0, 8'h8}; // Width bit
    srbg_top dut (.*);
    srbg_line_model u_line (.*);
    // 100 MHz clock
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // Write held until waitrequest is seen low
    task automatic bus_write(input logic [4:0] a, input logic [7:0] d, input logic [3:0] be = 4'h1);
        avs_address    <= a;
        avs_writedata  <= {24'h0, d};
        avs_byteenable <= be;
        avs_write      <= 1'b1;
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        @(posedge clock);
    endtask
    // Read; data taken at the acknowledging edge
    task automatic bus_read(input logic [4:0] a, output logic [31:0] d);
        avs_address <= a;
        avs_read    <= 1'b1;
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        d = avs_readdata;
        avs_read <= 1'b0;
        @(posedge clock);
    endtask
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_num(input int got, input int exp);
        chk_reg(got, exp);
    endtask
    task automatic read_expect(input logic [4:0] a, input logic [31:0] exp);
        logic [31:0] d;
        bus_read(a, d);
        chk_reg(d, exp);
    endtask
    // Clocks up to the next tick
    task automatic wait_tick(output int n);
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (rate_tick !== 1'b1);
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Watchdog against a hung handshake
    initial
    begin
        repeat (40000) @(posedge clock);
        n_mismatch++;
        report_and_stop();
    end
    // Main sequence
    initial
    begin
        int g;
        int k;
        {avs_read, avs_write, tx_data, rx_busy, avs_address, avs_writedata, avs_byteenable, reset_n} = '0;
        {n_mismatch, n_tests} = '0;
        repeat (20) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        // Reset values, unmapped and lane-less writes
        for (int i = 0; i < 8; i++) read_expect(5'(4 * i), (i == 0) ? 32'h40 : 32'h0);
        read_expect(5'h02, 32'h0);
        bus_write(OFS_DIVISOR_LOW, 8'h5a, 4'h0);
        bus_write(5'h1c, 8'hff);
        read_expect(OFS_DIVISOR_LOW, 32'h0);
        read_expect(5'h1c, 32'h0);
        rx_busy <= 1'b1;
        read_expect(OFS_RATE_CONTROL, 32'h0);
        rx_busy <= 1'b0;
        read_expect(OFS_RATE_CONTROL, 32'h40);
        // Seven of the eight mode settings (no sync wide low-rate); high divisor byte ignored when narrow
        for (int i = 0; i < 7; i++)
        begin
            bus_write(OFS_MODE_CONTROL, md[i]);
            bus_write(OFS_RATE_CONTROL, ct[i]);
            bus_write(OFS_DIVISOR_LOW, 8'h02);
            bus_write(OFS_DIVISOR_HIGH, 8'h01);
            wait_tick(g);
            wait_tick(g);
            chk_num(g, mul[i] * (ct[i][3] ? 259 : 3));
        end
        // Divisor write restarts a long count at once
        bus_write(OFS_MODE_CONTROL, 8'h0);
        bus_write(OFS_RATE_CONTROL, 8'h0);
        bus_write(OFS_DIVISOR_HIGH, 8'h00);
        bus_write(OFS_DIVISOR_LOW, 8'hff);
        repeat (300) @(posedge clock);
        bus_write(OFS_DIVISOR_LOW, 8'h00);
        wait_tick(g);
        chk_num(int'(g >= 60 && g <= 68), 1);
        // Pin data against polarity, tx data and mode
        for (int c = 0; c < 8; c++)
        begin
            bus_write(OFS_MODE_CONTROL, {7'h0, c[2]});
            bus_write(OFS_RATE_CONTROL, {3'h0, c[1], 4'h0});
            tx_data <= c[0];
            repeat (3) @(posedge clock);
            chk_reg({31'h0, transmit_clock_pin}, {31'h0, c[0] ^ (c[1] & !c[2])});
        end
        // Strobes per link edge; none in async mode
        for (int c = 0; c < 3; c++)
        begin
            bus_write(OFS_MODE_CONTROL, {7'h0, c < 2});
            bus_write(OFS_RATE_CONTROL, {3'h0, c[0], 4'h0});
            k = 0;
            fork
                u_line.clock_burst(8);
                repeat (115)
                begin
                    @(posedge clock);
                    if (data_strobe === 1'b1) k++;
                end
            join
            chk_num(k, (c < 2) ? 8 : 0);
        end
        // Wake with interrupt enabled, then masked
        bus_write(OFS_MODE_CONTROL, 8'h0);
        for (int m = 1; m >= 0; m--)
        begin
            bus_write(OFS_IRQ_ENABLE, m[7:0]);
            bus_write(OFS_RATE_CONTROL, 8'h02);
            u_line.send_char(8'hff, 10);
            read_expect(OFS_RATE_CONTROL, 32'h40);
            read_expect(OFS_IRQ_STATUS, 32'h1);
            chk_reg({31'h0, irq}, {31'h0, m[0]});
            bus_write(OFS_IRQ_CLEAR, 8'h01);
            read_expect(OFS_IRQ_STATUS, 32'h0);
            chk_reg({31'h0, irq}, 32'h0);
        end
        // Auto-rate on a 0x55 character, 160 clocks a bit
        bus_write(OFS_RATE_CONTROL, 8'h01);
        u_line.send_char(8'h55, 160);
        read_expect(OFS_RATE_CONTROL, 32'h40);
        read_expect(OFS_DIVISOR_LOW, 32'h1);
        read_expect(OFS_IRQ_STATUS, 32'h2);
        bus_write(OFS_IRQ_CLEAR, 8'h07);
        bus_write(OFS_DIVISOR_LOW, 8'h00);
        repeat (200) @(posedge clock);
        report_and_stop();
    end
endmodule // srbg_top_tb
`default_nettype wire
